// ==== hw/tlvi_top.sv ====
/*
 * Two-level vectored interrupt unit: request flags, enables, priorities,
 * machine-cycle sampling and polling, hardware call and in-progress tracking.
 * Assumes the core gives a sample-point strobe once per machine cycle, marks the
 * final cycle of each instruction, pulses on return-from-interrupt, and performs
 * the stack push and program counter load while the call output is valid.
 */
`default_nettype none
`include "tlvi_defs.svh"


module tlvi_top
	import tlvi_pkg::*;
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// machine cycle and instruction timing from the core
	input wire logic i_sample_point,
	input wire logic i_instr_last,
	input wire logic i_reti,
	// external request pins, active low
	input wire logic [6:0] i_ext_request_n,
	// peripheral set pulses and watchdog mode
	input wire tlvi_periph_t i_periph_set,
	input wire logic i_watchdog_nmi,
	// configuration writes
	input wire logic i_cfg_write,
	input wire logic [2:0] i_cfg_sel,
	input wire logic [7:0] i_cfg_wdata,
	// software flag writes
	input wire logic i_flag_write,
	input wire logic [4:0] i_flag_index,
	input wire logic i_flag_value,
	// call request and status
	output tlvi_call_t o_call,
	output logic [1:0] o_in_progress,
	output logic [19:0] o_flags
);
	logic [6:0] ext_sync;
	logic [6:0] ext_active;
	logic [6:0] edge_mode;
	logic [6:0] ext_prev_reg;
	logic [6:0] ext_prev_next;
	logic [19:0] flag_reg;
	logic [19:0] flag_next;
	logic [17:0] src_req;
	logic [17:0] sample_reg;
	logic [17:0] sample_next;
	logic [7:0] cfg_reg [7];
	logic [7:0] cfg_next [7];
	logic [17:0] en_vec;
	logic [17:0] pri_vec;
	logic [17:0] eff_req;
	logic [17:0] eff_high;
	logic arb_found;
	logic arb_level;
	logic [4:0] arb_index;
	logic hold_reg;
	logic hold_next;
	logic [1:0] inprog_reg;
	logic [1:0] inprog_next;
	tlvi_call_state_t state_reg;
	tlvi_call_state_t state_next;
	logic [1:0] cnt_reg;
	logic [1:0] cnt_next;
	tlvi_call_t call_reg;
	tlvi_call_t call_next;
	logic en_pri_write;
	logic poll_ok;
	logic start_call;
	logic clr_valid;
	logic [4:0] clr_idx;

	tlvi_sync u_sync (
		.i_sys_clk(i_sys_clk),
		.i_resetn(i_resetn),
		.i_async(i_ext_request_n),
		.o_sync(ext_sync)
	);

	assign ext_active = ~ext_sync;
	assign edge_mode = {1'b1, cfg_reg[`TLVI_SEL_TRIG][5:0]};

	// polling-order view of the flags
	always_comb begin
		src_req[0] = flag_reg[0];
		src_req[1] = flag_reg[`TLVI_FLAG_T0];
		src_req[2] = flag_reg[1];
		src_req[3] = flag_reg[`TLVI_FLAG_T1];
		src_req[4] = flag_reg[`TLVI_FLAG_URX] | flag_reg[`TLVI_FLAG_UTX];
		src_req[5] = flag_reg[`TLVI_FLAG_T2] | flag_reg[`TLVI_FLAG_T2X];
		src_req[6] = flag_reg[`TLVI_FLAG_WDT];
		src_req[7] = flag_reg[`TLVI_FLAG_IFC];
		src_req[8] = flag_reg[`TLVI_FLAG_ADC];
		src_req[9] = flag_reg[2];
		src_req[10] = flag_reg[3];
		src_req[11] = flag_reg[4];
		src_req[12] = flag_reg[`TLVI_FLAG_S1];
		src_req[13] = flag_reg[`TLVI_FLAG_S2];
		src_req[14] = flag_reg[5];
		src_req[15] = flag_reg[6];
		src_req[16] = flag_reg[`TLVI_FLAG_T3];
		src_req[17] = flag_reg[`TLVI_FLAG_T4];
	end

	// enables and priorities spread over three bytes each
	always_comb begin
		en_vec = {cfg_reg[`TLVI_SEL_EN_C][2:0], cfg_reg[`TLVI_SEL_EN_B],
			cfg_reg[`TLVI_SEL_EN_A][6:0]};
		pri_vec = {cfg_reg[`TLVI_SEL_PRI_C][6:0], cfg_reg[`TLVI_SEL_PRI_B][4:0],
			cfg_reg[`TLVI_SEL_PRI_A][5:0]};
		eff_req = sample_reg & en_vec & {18{cfg_reg[`TLVI_SEL_EN_A][`TLVI_GLOBAL_BIT]}};
		eff_high = pri_vec;
		// non-maskable watchdog ignores all enables and always ranks high
		if (i_watchdog_nmi) begin
			eff_req[`TLVI_WDT_SRC] = sample_reg[`TLVI_WDT_SRC];
			eff_high[`TLVI_WDT_SRC] = 1'b1;
		end
	end

	tlvi_arbiter u_arbiter (
		.i_req(eff_req),
		.i_high(eff_high),
		.i_allow_low(inprog_reg == 2'h0),
		.i_allow_high(!inprog_reg[1]),
		.o_found(arb_found),
		.o_level(arb_level),
		.o_index(arb_index)
	);

	// which flag, if any, the hardware clears when a source is vectored
	always_comb begin
		clr_valid = 1'b1;
		clr_idx = 5'h00;
		case (arb_index)
			5'h00: begin clr_idx = 5'h00; clr_valid = edge_mode[0]; end
			5'h01: clr_idx = 5'(`TLVI_FLAG_T0);
			5'h02: begin clr_idx = 5'h01; clr_valid = edge_mode[1]; end
			5'h03: clr_idx = 5'(`TLVI_FLAG_T1);
			5'h05: clr_idx = 5'(`TLVI_FLAG_T2);
			5'h09: begin clr_idx = 5'h02; clr_valid = edge_mode[2]; end
			5'h0A: begin clr_idx = 5'h03; clr_valid = edge_mode[3]; end
			5'h0B: begin clr_idx = 5'h04; clr_valid = edge_mode[4]; end
			5'h0E: begin clr_idx = 5'h05; clr_valid = edge_mode[5]; end
			5'h0F: clr_idx = 5'h06;
			5'h10: clr_idx = 5'(`TLVI_FLAG_T3);
			5'h11: clr_idx = 5'(`TLVI_FLAG_T4);
			default: clr_valid = 1'b0;
		endcase
	end

	assign en_pri_write = i_cfg_write && (i_cfg_sel <= `TLVI_SEL_PRI_C);
	// a return or enable/priority write in this instruction blocks its poll
	assign poll_ok = i_sample_point && i_instr_last && !hold_reg && !i_reti
		&& !en_pri_write && (state_reg == CALL_IDLE);
	assign start_call = poll_ok && arb_found;

	// request flags
	always_comb begin
		flag_next = flag_reg;
		ext_prev_next = ext_prev_reg;
		sample_next = sample_reg;
		if (i_sample_point) begin
			// fresh snapshot each cycle, nothing carried from a denied poll
			sample_next = src_req;
			ext_prev_next = ext_active;
			for (int i = 0; i < 6; i++) begin
				if (!edge_mode[i]) begin
					flag_next[i] = ext_active[i];
				end
			end
		end
		if (i_flag_write && (i_flag_index < 5'(`TLVI_NUM_FLAG))) begin
			flag_next[i_flag_index] = i_flag_value;
		end
		if (start_call && clr_valid) begin
			flag_next[clr_idx] = 1'b0;
		end
		// sets last so a set beats a clear in the same cycle
		if (i_sample_point) begin
			for (int i = 0; i < 7; i++) begin
				if (edge_mode[i] && ext_active[i] && !ext_prev_reg[i]) begin
					flag_next[i] = 1'b1;
				end
			end
		end
		flag_next[19:7] = flag_next[19:7] | i_periph_set;
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			flag_reg <= 20'h00000;
			ext_prev_reg <= 7'h00;
			sample_reg <= 18'h00000;
		end else begin
			flag_reg <= flag_next;
			ext_prev_reg <= ext_prev_next;
			sample_reg <= sample_next;
		end
	end

	// configuration bytes; reserved priority bits never stored
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			cfg_next[i] = cfg_reg[i];
		end
		if (i_cfg_write) begin
			case (i_cfg_sel)
				`TLVI_SEL_EN_A: cfg_next[0] = i_cfg_wdata & `TLVI_MASK_EN_A;
				`TLVI_SEL_EN_B: cfg_next[1] = i_cfg_wdata & `TLVI_MASK_EN_B;
				`TLVI_SEL_EN_C: cfg_next[2] = i_cfg_wdata & `TLVI_MASK_EN_C;
				`TLVI_SEL_PRI_A: cfg_next[3] = i_cfg_wdata & `TLVI_MASK_PRI_A;
				`TLVI_SEL_PRI_B: cfg_next[4] = i_cfg_wdata & `TLVI_MASK_PRI_B;
				`TLVI_SEL_PRI_C: cfg_next[5] = i_cfg_wdata & `TLVI_MASK_PRI_C;
				`TLVI_SEL_TRIG: cfg_next[6] = i_cfg_wdata & `TLVI_MASK_TRIG;
				default: cfg_next[0] = cfg_reg[0];
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int i = 0; i < 7; i++) begin
				cfg_reg[i] <= `TLVI_CFG_RESET;
			end
		end else begin
			for (int i = 0; i < 7; i++) begin
				cfg_reg[i] <= cfg_next[i];
			end
		end
	end

	// one-instruction hold and in-progress levels
	always_comb begin
		hold_next = hold_reg;
		if (i_sample_point && i_instr_last) begin
			hold_next = 1'b0;
		end else if (i_reti || en_pri_write) begin
			hold_next = 1'b1;
		end
		// a plain return has no port here, so it cannot touch these bits
		inprog_next = inprog_reg;
		if (i_reti) begin
			if (inprog_reg[1]) begin
				inprog_next[1] = 1'b0;
			end else begin
				inprog_next[0] = 1'b0;
			end
		end
		if (start_call) begin
			inprog_next[arb_level] = 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			hold_reg <= 1'b0;
			inprog_reg <= 2'h0;
		end else begin
			hold_reg <= hold_next;
			inprog_reg <= inprog_next;
		end
	end

	// call sequencer: vector held for the two machine cycles of the call
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		call_next = call_reg;
		case (state_reg)
			CALL_IDLE: begin
				if (start_call) begin
					state_next = CALL_BUSY;
					cnt_next = `TLVI_CALL_CYCLES;
					call_next.valid = 1'b1;
					call_next.level = arb_level;
					call_next.vector = `TLVI_VEC_BASE
						+ {8'h00, arb_index, 3'h0};
				end
			end
			CALL_BUSY: begin
				if (i_sample_point) begin
					cnt_next = cnt_reg - 2'h1;
					if (cnt_reg == 2'h1) begin
						state_next = CALL_IDLE;
						call_next.valid = 1'b0;
					end
				end
			end
			default: begin
				state_next = CALL_IDLE;
				call_next.valid = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_reg <= CALL_IDLE;
			cnt_reg <= 2'h0;
			call_reg <= '0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			call_reg <= call_next;
		end
	end

	assign o_call = call_reg;
	assign o_in_progress = inprog_reg;
	assign o_flags = flag_reg;
endmodule // tlvi_top

`default_nettype wire

// ==== pkg/tlvi_defs.svh ====
/*
 * Constants of the two-level vectored interrupt unit: vector layout, call length,
 * configuration selects, writable-bit masks and request flag positions.
 * Assumes it is included once per compilation unit by its bare name.
 */
`ifndef TLVI_DEFS_SVH
`define TLVI_DEFS_SVH

`define TLVI_NUM_SRC 18
`define TLVI_NUM_EXT 7
`define TLVI_NUM_FLAG 20
`define TLVI_VEC_BASE 16'h0003
`define TLVI_VEC_SHIFT 3
`define TLVI_CALL_CYCLES 2'h2
`define TLVI_CFG_RESET 8'h00
`define TLVI_WDT_SRC 5'h06

// configuration select codes
`define TLVI_SEL_EN_A 3'h0
`define TLVI_SEL_EN_B 3'h1
`define TLVI_SEL_EN_C 3'h2
`define TLVI_SEL_PRI_A 3'h3
`define TLVI_SEL_PRI_B 3'h4
`define TLVI_SEL_PRI_C 3'h5
`define TLVI_SEL_TRIG 3'h6
`define TLVI_GLOBAL_BIT 7

// writable bits per configuration byte
`define TLVI_MASK_EN_A 8'hFF
`define TLVI_MASK_EN_B 8'hFF
`define TLVI_MASK_EN_C 8'h07
`define TLVI_MASK_PRI_A 8'h3F
`define TLVI_MASK_PRI_B 8'h1F
`define TLVI_MASK_PRI_C 8'h7F
`define TLVI_MASK_TRIG 8'h3F

// request flag positions, external pins occupy 0..6
`define TLVI_FLAG_T0 7
`define TLVI_FLAG_T1 8
`define TLVI_FLAG_URX 9
`define TLVI_FLAG_UTX 10
`define TLVI_FLAG_T2 11
`define TLVI_FLAG_T2X 12
`define TLVI_FLAG_WDT 13
`define TLVI_FLAG_IFC 14
`define TLVI_FLAG_ADC 15
`define TLVI_FLAG_S1 16
`define TLVI_FLAG_S2 17
`define TLVI_FLAG_T3 18
`define TLVI_FLAG_T4 19

`endif

// ==== pkg/tlvi_pkg.sv ====
/*
 * Types of the two-level vectored interrupt unit.
 * Assumes the defines header is compiled alongside; field order of the
 * peripheral struct matches the flag positions in the header.
 */
`default_nettype none

package tlvi_pkg;

	// msb first: timer4 sits at flag 19, timer0 at flag 7
	typedef struct packed {
		logic timer4_overflow_flag;
		logic timer3_overflow_flag;
		logic serial2_request_flag;
		logic serial1_request_flag;
		logic converter_request_flag;
		logic ifcount_request_flag;
		logic watchdog_request_flag;
		logic timer2_external_flag;
		logic timer2_overflow_flag;
		logic uart_transmit_flag;
		logic uart_receive_flag;
		logic timer1_overflow_flag;
		logic timer0_overflow_flag;
	} tlvi_periph_t;

	typedef struct packed {
		logic valid;
		logic level;
		logic [15:0] vector;
	} tlvi_call_t;

	typedef enum logic {
		CALL_IDLE,
		CALL_BUSY
	} tlvi_call_state_t;

endpackage

`default_nettype wire

// ==== hw/tlvi_sync.sv ====
/*
 * Two-flop synchroniser for the external request pins.
 * Assumes pins idle high, so both stages reset to ones.
 */
`default_nettype none

module tlvi_sync (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// pins and synchronised copy
	input wire logic [6:0] i_async,
	output logic [6:0] o_sync
);
	logic [6:0] meta_reg;
	logic [6:0] sync_reg;

	// first stage read only by the second
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			meta_reg <= 7'h7F;
			sync_reg <= 7'h7F;
		end else begin
			meta_reg <= i_async;
			sync_reg <= meta_reg;
		end
	end

	assign o_sync = sync_reg;
endmodule // tlvi_sync

`default_nettype wire

// ==== hw/tlvi_arbiter.sv ====
/*
 * Combinational winner selection over the eighteen polled requests.
 * Assumes requests are already enable-gated; index 0 is first in polling order.
 */
`default_nettype none

module tlvi_arbiter
	import tlvi_pkg::*;
(
	// requests and their levels
	input wire logic [17:0] i_req,
	input wire logic [17:0] i_high,
	input wire logic i_allow_low,
	input wire logic i_allow_high,
	// winner
	output logic o_found,
	output logic o_level,
	output logic [4:0] o_index
);
	logic [17:0] hi_req;
	logic [17:0] lo_req;

	always_comb begin
		hi_req = i_req & i_high & {18{i_allow_high}};
		lo_req = i_req & ~i_high & {18{i_allow_low}};
		o_found = 1'b0;
		o_level = 1'b0;
		o_index = 5'h00;
		// scan downward so the earliest in polling order lands last
		for (int i = 17; i >= 0; i--) begin
			if (lo_req[i]) begin
				o_index = 5'(i);
			end
		end
		for (int i = 17; i >= 0; i--) begin
			if (hi_req[i]) begin
				o_index = 5'(i);
			end
		end
		o_found = |hi_req | |lo_req;
		o_level = |hi_req;
	end
endmodule // tlvi_arbiter

`default_nettype wire

// ==== tb/tlvi_top_props.sv ====
/*
 * Checker for the two-level vectored interrupt unit, bound to its top module.
 * Assumes one clock domain and the asynchronous active-low reset.
 */
`default_nettype none

module tlvi_top_props
	import tlvi_pkg::*;
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// core timing
	input wire logic i_sample_point,
	input wire logic i_instr_last,
	input wire logic i_reti,
	// requests and writes
	input wire tlvi_periph_t i_periph_set,
	input wire logic i_cfg_write,
	input wire logic [2:0] i_cfg_sel,
	input wire logic i_flag_write,
	input wire logic [4:0] i_flag_index,
	input wire logic i_flag_value,
	// outputs
	input wire tlvi_call_t o_call,
	input wire logic [1:0] o_in_progress,
	input wire logic [19:0] o_flags
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);

	// sample points seen while a call stands
	logic [1:0] sp_seen_reg;
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn)
			sp_seen_reg <= 2'h0;
		else if (!o_call.valid)
			sp_seen_reg <= 2'h0;
		else if (i_sample_point)
			sp_seen_reg <= sp_seen_reg + 2'h1;
	end

	sequence s_start;
		$rose(o_call.valid);
	endsequence
	sequence s_block;
		(i_reti || (i_cfg_write && i_cfg_sel < 3'h6)) && !o_call.valid;
	endsequence

	a_vector_grid: assert property (o_call.valid |-> o_call.vector[2:0] == 3'h3 &&
		o_call.vector[15:3] <= 13'h0011) else $error("vector off grid");
	a_call_marks: assert property (s_start |-> o_in_progress[o_call.level])
		else $error("level not marked busy");
	a_call_final: assert property (s_start |-> $past(i_sample_point && i_instr_last))
		else $error("call outside final sample point");
	a_low_idle: assert property (s_start ##0 !o_call.level |-> $past(o_in_progress) == 2'h0)
		else $error("low call while busy");
	a_high_once: assert property (s_start |-> !$past(o_in_progress[1]))
		else $error("high routine preempted");
	a_block_after: assert property (s_block |=> !o_call.valid)
		else $error("call right after return or config");
	a_reti_top: assert property (i_reti |=> o_in_progress ==
		($past(o_in_progress[1]) ? {1'h0, $past(o_in_progress[0])} : 2'h0))
		else $error("return cleared wrong level");
	a_call_ends: assert property (o_call.valid && i_sample_point && sp_seen_reg == 2'h1
		|=> !o_call.valid) else $error("call too long");
	a_call_stands: assert property (o_call.valid && !(i_sample_point && sp_seen_reg == 2'h1)
		|=> o_call.valid) else $error("call too short");
	a_timer_clear: assert property (s_start ##0 o_call.vector == 16'h000B |-> !o_flags[7] ||
		$past(i_periph_set.timer0_overflow_flag || i_flag_write)) else $error("timer flag kept");
	a_uart_kept: assert property (s_start ##0 o_call.vector == 16'h0023 |->
		o_flags[10:9] == $past(o_flags[10:9]) || $past(i_flag_write || (|i_periph_set)))
		else $error("uart flags changed");
	a_sw_set: assert property (i_flag_write && i_flag_value && i_flag_index < 5'h14 &&
		!i_sample_point |=> o_flags[$past(i_flag_index)]) else $error("software set lost");
endmodule // tlvi_top_props

bind tlvi_top tlvi_top_props u_props (.i_sys_clk, .i_resetn, .i_sample_point, .i_instr_last,
	.i_reti, .i_periph_set, .i_cfg_write, .i_cfg_sel, .i_flag_write, .i_flag_index,
	.i_flag_value, .o_call, .o_in_progress, .o_flags);

`default_nettype wire

// ==== tb/tlvi_core_model.sv ====
/*
 * Behavioural core: machine-cycle strobes, return instruction, call stack.
 * Assumes the bench drives its commands off the rising edge.
 */
`default_nettype none

module tlvi_core_model #(
	parameter int MC = 6
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// bench commands and the unit's call
	input wire logic i_last_en,
	input wire logic i_ret_go,
	input wire logic i_call_valid,
	input wire logic [15:0] i_call_vector,
	// timing to the unit, program counter
	output logic o_sample_point,
	output logic o_instr_last,
	output logic o_reti,
	output logic [15:0] o_pc
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	logic pend, vld_q;
	logic [15:0] stk [$];
	wire logic at_end = (cnt == MC - 1) && i_last_en;

	assign o_instr_last = i_last_en;
	always @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt <= 0;
			pend <= 1'h0;
			vld_q <= 1'h0;
			o_sample_point <= 1'h0;
			o_reti <= 1'h0;
			o_pc <= 16'h0100;
		end else begin
			cnt <= (cnt == MC - 1) ? 0 : cnt + 1;
			o_sample_point <= (cnt == MC - 1);
			// return only in an instruction's last cycle
			o_reti <= pend && at_end;
			pend <= (pend && !at_end) || i_ret_go;
			vld_q <= i_call_valid;
			if (i_call_valid && !vld_q) begin
				stk.push_back(o_pc);
				o_pc <= i_call_vector;
			end else if (o_reti && stk.size() > 0)
				o_pc <= stk.pop_back();
		end
	end
endmodule // tlvi_core_model

`default_nettype wire

// ==== tb/tb_tlvi_top.sv ====
/*
 * Self-checking bench of the two-level vectored interrupt unit.
 * Assumes the core model paces machine cycles; pins idle high.
 */
`default_nettype none
`include "tlvi_defs.svh"

module tb_tlvi_top
	import tlvi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MC = 6;
	localparam logic [4:0] FMAP [18] = '{5'h00, 5'h07, 5'h01, 5'h08, 5'h09, 5'h0B, 5'h0D,
		5'h0E, 5'h0F, 5'h02, 5'h03, 5'h04, 5'h10, 5'h11, 5'h05, 5'h06, 5'h12, 5'h13};
	localparam logic [17:0] KEEP = 18'h031D0;
	logic clk = 1'h0, rstn = 1'h0, sp, il, reti, last_en = 1'h1, ret_go = 1'h0, nmi = 1'h0;
	logic cw = 1'h0, fw = 1'h0, fv = 1'h0;
	logic [2:0] sel = 3'h0;
	logic [7:0] wd = 8'h00;
	logic [4:0] fi = 5'h00;
	logic [6:0] pins = 7'h7F;
	tlvi_periph_t pset = '0;
	tlvi_call_t call;
	logic [1:0] inprog;
	logic [19:0] flags;
	logic [15:0] pc;
	int n_mismatch = 0, total_checks = 0;

	always #10 clk = ~clk;

	tlvi_core_model #(.MC(MC)) u_core (.i_sys_clk(clk), .i_resetn(rstn), .i_last_en(last_en),
		.i_ret_go(ret_go), .i_call_valid(call.valid), .i_call_vector(call.vector),
		.o_sample_point(sp), .o_instr_last(il), .o_reti(reti), .o_pc(pc));
	tlvi_top dut (.i_sys_clk(clk), .i_resetn(rstn), .i_sample_point(sp), .i_instr_last(il),
		.i_reti(reti), .i_ext_request_n(pins), .i_periph_set(pset), .i_watchdog_nmi(nmi),
		.i_cfg_write(cw), .i_cfg_sel(sel), .i_cfg_wdata(wd), .i_flag_write(fw),
		.i_flag_index(fi), .i_flag_value(fv), .o_call(call), .o_in_progress(inprog),
		.o_flags(flags));

	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cfg(input logic [2:0] s, input logic [7:0] d);
		@(negedge clk);
		{cw, sel, wd} = {1'h1, s, d};
		@(negedge clk);
		cw = 1'h0;
	endtask
	task automatic flg(input logic [4:0] i, input logic v);
		@(negedge clk);
		{fw, fi, fv} = {1'h1, i, v};
		@(negedge clk);
		fw = 1'h0;
	endtask
	task automatic hw_set(input logic [12:0] p);
		@(negedge clk);
		pset = tlvi_periph_t'(p);
		@(negedge clk);
		pset = '0;
	endtask
	task automatic expect_call(input logic [15:0] v, input logic lv);
		// a call still standing from the last scenario must not be taken for this one
		wait_idle();
		for (int n = 0; n < 80 && call.valid !== 1'h1; n++) @(negedge clk);
		@(negedge clk);
		chk(call.valid, 1'h1);
		chk(call.vector, v);
		chk(call.level, lv);
		chk(pc, v);
	endtask
	task automatic wait_idle();
		for (int n = 0; n < 80 && call.valid !== 1'h0; n++) @(negedge clk);
	endtask
	task automatic do_reti();
		wait_idle();
		ret_go = 1'h1;
		@(negedge clk);
		ret_go = 1'h0;
		for (int n = 0; n < 80 && reti !== 1'h1; n++) @(negedge clk);
		@(negedge clk);
	endtask
	// a poll could fire anywhere in four machine cycles
	task automatic quiet();
		logic seen = 1'h0;
		wait_idle();
		for (int n = 0; n < 4 * MC; n++) begin
			@(negedge clk);
			seen |= call.valid;
		end
		chk(seen, 1'h0);
	endtask

	task automatic t_order();
		cfg(`TLVI_SEL_TRIG, 8'h3F);
		for (int k = 0; k < 18; k++) flg(FMAP[k], 1'h1);
		cfg(`TLVI_SEL_EN_B, 8'hFF);
		cfg(`TLVI_SEL_EN_C, 8'h07);
		cfg(`TLVI_SEL_EN_A, 8'hFF);
		for (int k = 0; k < 18; k++) begin
			expect_call(16'h0003 + 16'(k * 8), 1'h0);
			chk(inprog, 2'h1);
			chk(flags[FMAP[k]], KEEP[k]);
			flg(FMAP[k], 1'h0);
			do_reti();
			chk(inprog, 2'h0);
		end
		cfg(`TLVI_SEL_EN_A, 8'h00);
	endtask
	task automatic t_prio();
		cfg(`TLVI_SEL_PRI_C, 8'h40);
		flg(5'h00, 1'h1);
		hw_set(13'h1000);
		cfg(`TLVI_SEL_EN_C, 8'h04);
		cfg(`TLVI_SEL_EN_A, 8'h81);
		expect_call(16'h008B, 1'h1);
		chk(flags[19], 1'h0);
		quiet();
		chk(inprog, 2'h2);
		do_reti();
		expect_call(16'h0003, 1'h0);
		hw_set(13'h1000);
		expect_call(16'h008B, 1'h1);
		chk(inprog, 2'h3);
		do_reti();
		chk(inprog, 2'h1);
		do_reti();
		chk(inprog, 2'h0);
	endtask
	task automatic t_block();
		cfg(`TLVI_SEL_EN_A, 8'h02);
		hw_set(13'h0001);
		chk(flags[7], 1'h1);
		quiet();
		last_en = 1'h0;
		cfg(`TLVI_SEL_EN_A, 8'h82);
		quiet();
		flg(5'h07, 1'h0);
		last_en = 1'h1;
		quiet();
		cfg(`TLVI_SEL_EN_A, 8'h00);
		nmi = 1'h1;
		hw_set(13'h0040);
		expect_call(16'h0033, 1'h1);
		flg(5'h0D, 1'h0);
		nmi = 1'h0;
		do_reti();
	endtask
	task automatic t_level();
		cfg(`TLVI_SEL_TRIG, 8'h00);
		cfg(`TLVI_SEL_EN_C, 8'h01);
		cfg(`TLVI_SEL_EN_A, 8'h81);
		pins[0] = 1'h0;
		expect_call(16'h0003, 1'h0);
		chk(flags[0], 1'h1);
		pins[0] = 1'h1;
		// flag refreshed at each sample point
		repeat (2 * MC) @(negedge clk);
		chk(flags[0], 1'h0);
		do_reti();
		pins[6] = 1'h0;
		expect_call(16'h007B, 1'h0);
		chk(flags[6], 1'h0);
		pins[6] = 1'h1;
		do_reti();
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (12) @(negedge clk);
		rstn = 1'h1;
		@(negedge clk);
		chk({call, inprog}, 20'h00000);
		chk(flags, 20'h00000);
		t_order();
		t_prio();
		t_block();
		t_level();
		conclude();
	end
	initial begin
		repeat (30000) @(posedge clk);
		n_mismatch++;
		conclude();
	end
endmodule // tb_tlvi_top

`default_nettype wire
